/* File: design/flash_sector_protection_ctrl.v */
// Sector protection, lock bit and write-enable latch logic of the serial flash.
`include "flash_prot_regs.vh"
`default_nettype none
module flash_sector_protection_ctrl (
   input  wire        clock,
   input  wire        rst,
   input  wire        cs_n,
   input  wire        sck,
   input  wire        mosi,
   input  wire        wp_n,
   input  wire        suspend_any,
   output reg  [15:0] sector_prot_ff,
   output reg         write_enable_latch_ff,
   output reg         protection_lock_bit_ff,
   output reg  [7:0]  status_byte1_ff
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_OPC  = 2'b01;
   localparam [1:0] ST_ARG  = 2'b10;
   localparam [1:0] ST_SKIP = 2'b11;

   wire       frame_start;
   wire       frame_end;
   wire       byte_valid;
   wire [7:0] byte_data;
   wire       bit_aligned;
   wire       wp_n_s;

   reg  [1:0] state_ff;
   reg  [1:0] nxt_state;
   reg  [7:0] opcode_ff;
   reg  [2:0] byte_cnt_ff;
   reg  [3:0] sector_sel_ff;
   reg  [7:0] wr_data_ff;
   reg        susp_ff;

   spi_frame_rx u_rx (
      .clock          (clock),
      .rst            (rst),
      .cs_n_pin       (cs_n),
      .sck_pin        (sck),
      .mosi_pin       (mosi),
      .wp_n_pin       (wp_n),
      .frame_start_ff (frame_start),
      .frame_end_ff   (frame_end),
      .byte_valid_ff  (byte_valid),
      .byte_data_ff   (byte_data),
      .bit_aligned_ff (bit_aligned),
      .wp_n_sync      (wp_n_s)
   );

   // Frame-end decode of the completed command.
   // Sector commands need the opcode plus three address bytes, status writes one data byte.
   wire is_prot   = (opcode_ff == `OPC_PROTECT_SECTOR);
   wire is_unprot = (opcode_ff == `OPC_UNPROTECT_SECTOR);
   wire is_wsr    = (opcode_ff == `OPC_WRITE_STATUS1);
   wire is_sector = is_prot || is_unprot;
   wire is_wel_op = is_sector || is_wsr;
   wire sect_full = (byte_cnt_ff >= `ADDR_BYTES_DONE) && bit_aligned;
   wire wsr_full  = (byte_cnt_ff >= `STATUS_BYTES_DONE) && bit_aligned;
   wire opc_full  = (byte_cnt_ff >= `CMD_BYTES_DONE) && bit_aligned;
   wire run_sect  = frame_end && is_sector && sect_full && write_enable_latch_ff
                    && !protection_lock_bit_ff;
   wire run_wsr   = frame_end && is_wsr && wsr_full && write_enable_latch_ff;

   // Global operation decode; bits 5..2 are decoded here and never stored.
   // A set lock blocks both global operations; suspended work blocks only Global Protect.
   wire [3:0] gbits    = wr_data_ff[`SR_GLOBAL_MSB:`SR_GLOBAL_LSB];
   wire       g_all1   = (gbits == 4'hF);
   wire       g_all0   = (gbits == 4'h0);
   wire       run_glob = run_wsr && !protection_lock_bit_ff;
   wire       g_abort  = run_glob && g_all1 && susp_ff;
   wire       g_prot   = run_glob && g_all1 && !susp_ff;
   wire       g_unpr   = run_glob && g_all0;

   // Command framing: opcode byte, then argument bytes, then ignored trailing bytes.
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (frame_start) begin
               nxt_state = ST_OPC;
            end
         end
         ST_OPC: begin
            if (byte_valid) begin
               nxt_state = ST_ARG;
            end
         end
         ST_ARG: begin
            if (byte_valid && (byte_cnt_ff == 3'h3)) begin
               nxt_state = ST_SKIP;
            end
         end
         ST_SKIP: begin
            // Bytes past the third address byte never reach the decode.
            nxt_state = ST_SKIP;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (frame_end) begin
         nxt_state = ST_IDLE;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         state_ff      <= ST_IDLE;
         opcode_ff     <= 8'h00;
         byte_cnt_ff   <= 3'h0;
         sector_sel_ff <= 4'h0;
         wr_data_ff    <= 8'h00;
         susp_ff       <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         susp_ff  <= suspend_any;
         if (frame_start) begin
            byte_cnt_ff <= 3'h0;
            opcode_ff   <= 8'h00;
         end else if (byte_valid && (state_ff != ST_SKIP) && (state_ff != ST_IDLE)) begin
            // The count stops at four because the skip state is reached by then.
            byte_cnt_ff <= byte_cnt_ff + 3'h1;
            if (state_ff == ST_OPC) begin
               opcode_ff <= byte_data;
            end
            if (byte_cnt_ff == 3'h1) begin
               // First address byte carries the sector number; low 16 bits are unused.
               sector_sel_ff <= byte_data[`SECTOR_SEL_MSB-`SECTOR_SEL_LSB:0];
               wr_data_ff    <= byte_data;
            end
         end
      end
   end

   // Write enable and disable act only on a whole opcode ended on a byte boundary.
   wire wel_set = (opcode_ff == `OPC_WRITE_ENABLE) && opc_full;
   wire wel_clr = (opcode_ff == `OPC_WRITE_DISABLE) && opc_full;

   // Write-enable latch.
   always @(posedge clock) begin
      if (rst) begin
         write_enable_latch_ff <= 1'b0;
      end else if (frame_end) begin
         if (wel_set) begin
            write_enable_latch_ff <= 1'b1;
         end else if (wel_clr) begin
            write_enable_latch_ff <= 1'b0;
         end else if (is_wel_op) begin
            // Done, aborted, locked or refused: the latch always falls.
            write_enable_latch_ff <= 1'b0;
         end
      end
   end

   // Lock bit: only bit 7 of a status write is ever stored.
   reg nxt_lock;
   always @* begin
      nxt_lock = protection_lock_bit_ff;
      if (run_wsr && !g_abort) begin
         if (!protection_lock_bit_ff) begin
            nxt_lock = wr_data_ff[`SR_LOCK_BIT];
         end else if (!wr_data_ff[`SR_LOCK_BIT] && wp_n_s) begin
            // Once set, the lock can only be dropped while the write-protect pin is high.
            nxt_lock = 1'b0;
         end
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         protection_lock_bit_ff <= 1'b0;
      end else begin
         protection_lock_bit_ff <= nxt_lock;
      end
   end

   // One protection bit per 64KB sector; every sector comes out of reset protected.
   // A global operation outranks a sector command, though the two never share a frame end.
   wire [15:0] prot_reset_bits = `SECTOR_PROT_RESET;
   genvar s;
   generate
      for (s = 0; s < `SECTOR_COUNT; s = s + 1) begin : g_sector
         always @(posedge clock) begin
            if (rst) begin
               sector_prot_ff[s] <= prot_reset_bits[s];
            end else if (g_prot) begin
               sector_prot_ff[s] <= 1'b1;
            end else if (g_unpr) begin
               sector_prot_ff[s] <= 1'b0;
            end else if (run_sect && (sector_sel_ff == s)) begin
               sector_prot_ff[s] <= is_prot;
            end
         end
      end
   endgenerate

   // Protection summary: all sectors protected, some protected, or none.
   reg [1:0] nxt_swp;
   always @* begin
      if (&sector_prot_ff) begin
         nxt_swp = 2'b11;
      end else if (|sector_prot_ff) begin
         nxt_swp = 2'b01;
      end else begin
         nxt_swp = 2'b00;
      end
   end

   // Status byte 1 as read back: bit 4 is the pin level, bits 3..2 the protection summary.
   always @(posedge clock) begin
      if (rst) begin
         status_byte1_ff <= 8'h00;
      end else begin
         status_byte1_ff <= 8'h00;
         status_byte1_ff[`SR_LOCK_BIT] <= protection_lock_bit_ff;
         status_byte1_ff[`SR_WP_BIT]   <= wp_n_s;
         status_byte1_ff[`SR_SWP_MSB:`SR_SWP_LSB] <= nxt_swp;
         status_byte1_ff[`SR_WEL_BIT]  <= write_enable_latch_ff;
      end
   end
endmodule
`default_nettype wire

/* File: design/flash_prot_regs.vh */
// Constants for the flash sector protection controller.
`ifndef FLASH_PROT_REGS_VH
`define FLASH_PROT_REGS_VH

`define OPC_WRITE_ENABLE     8'h06
`define OPC_WRITE_DISABLE    8'h04
`define OPC_WRITE_STATUS1    8'h01
`define OPC_PROTECT_SECTOR   8'h36
`define OPC_UNPROTECT_SECTOR 8'h39

`define SECTOR_COUNT         16
`define SECTOR_PROT_RESET    16'hFFFF
`define SECTOR_SEL_LSB       16
`define SECTOR_SEL_MSB       19

`define SR_LOCK_BIT          7
`define SR_GLOBAL_MSB        5
`define SR_GLOBAL_LSB        2
`define SR_WP_BIT            4
`define SR_SWP_MSB           3
`define SR_SWP_LSB           2
`define SR_WEL_BIT           1

`define ADDR_BYTES_DONE      3'h4
`define STATUS_BYTES_DONE    3'h2
`define CMD_BYTES_DONE       3'h1

`endif

/* File: design/spi_frame_rx.v */
// Pin synchroniser and serial byte receiver for the command link.
`default_nettype none
module spi_frame_rx (
   input  wire       clock,
   input  wire       rst,
   input  wire       cs_n_pin,
   input  wire       sck_pin,
   input  wire       mosi_pin,
   input  wire       wp_n_pin,
   output reg        frame_start_ff,
   output reg        frame_end_ff,
   output reg        byte_valid_ff,
   output reg  [7:0] byte_data_ff,
   output reg        bit_aligned_ff,
   output wire       wp_n_sync
);
   wire [3:0] pins_raw;
   reg  [3:0] meta_ff;
   reg  [3:0] sync_ff;
   reg        sck_prev_ff;
   reg        cs_n_prev_ff;
   reg  [2:0] bit_cnt_ff;
   reg  [6:0] shift_ff;
   wire       cs_n_s;
   wire       sck_s;
   wire       mosi_s;
   wire       sck_rise;

   assign pins_raw = {wp_n_pin, mosi_pin, sck_pin, cs_n_pin};

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_sync
         always @(posedge clock) begin
            if (rst) begin
               meta_ff[g] <= (g == 1 || g == 2) ? 1'b0 : 1'b1;
               sync_ff[g] <= (g == 1 || g == 2) ? 1'b0 : 1'b1;
            end else begin
               meta_ff[g] <= pins_raw[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   assign cs_n_s    = sync_ff[0];
   assign sck_s     = sync_ff[1];
   assign mosi_s    = sync_ff[2];
   assign wp_n_sync = sync_ff[3];
   assign sck_rise  = sck_s && !sck_prev_ff && !cs_n_s;

   always @(posedge clock) begin
      if (rst) begin
         sck_prev_ff    <= 1'b0;
         cs_n_prev_ff   <= 1'b1;
         bit_cnt_ff     <= 3'h0;
         shift_ff       <= 7'h00;
         byte_data_ff   <= 8'h00;
         byte_valid_ff  <= 1'b0;
         frame_start_ff <= 1'b0;
         frame_end_ff   <= 1'b0;
         bit_aligned_ff <= 1'b1;
      end else begin
         sck_prev_ff    <= sck_s;
         cs_n_prev_ff   <= cs_n_s;
         frame_start_ff <= cs_n_prev_ff && !cs_n_s;
         frame_end_ff   <= !cs_n_prev_ff && cs_n_s;
         byte_valid_ff  <= 1'b0;
         if (cs_n_prev_ff && !cs_n_s) begin
            bit_cnt_ff     <= 3'h0;
            bit_aligned_ff <= 1'b1;
         end else if (sck_rise) begin
            bit_cnt_ff     <= bit_cnt_ff + 3'h1;
            bit_aligned_ff <= (bit_cnt_ff == 3'h7);
            shift_ff       <= {shift_ff[5:0], mosi_s};
            if (bit_cnt_ff == 3'h7) begin
               byte_data_ff  <= {shift_ff, mosi_s};
               byte_valid_ff <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/flash_prot_sva.sv */
// Checker of the sector protection controller outputs.
`default_nettype none
module flash_prot_sva (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        cs_n,
   input wire logic        wp_n,
   input wire logic        suspend_any,
   input wire logic [15:0] sector_prot_ff,
   input wire logic        write_enable_latch_ff,
   input wire logic        protection_lock_bit_ff,
   input wire logic [7:0]  status_byte1_ff
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_rst; $fell(rst) |-> sector_prot_ff == 16'hFFFF && !write_enable_latch_ff; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_end; ($changed(sector_prot_ff) || $changed(write_enable_latch_ff)) && !$past(rst)
      |-> $past(cs_n); endproperty
   a_end: assert property (p_end) else $error("change inside a frame");
   property p_lock; $past(protection_lock_bit_ff) && !$past(rst) |-> $stable(sector_prot_ff);
   endproperty
   a_lock: assert property (p_lock) else $error("locked sectors changed");
   property p_wel; $changed(sector_prot_ff) && !$past(rst)
      |-> $past(write_enable_latch_ff) && !write_enable_latch_ff; endproperty
   a_wel: assert property (p_wel) else $error("latch not honoured");
   property p_one; $changed(sector_prot_ff) && !$past(rst) |-> sector_prot_ff == 16'h0000 ||
      sector_prot_ff == 16'hFFFF || $onehot(sector_prot_ff ^ $past(sector_prot_ff)); endproperty
   a_one: assert property (p_one) else $error("bad sector update");
   property p_susp; $past(suspend_any) && !$past(rst)
      |-> $countones(sector_prot_ff) <= $countones($past(sector_prot_ff)) + 1; endproperty
   a_susp: assert property (p_susp) else $error("protect while suspended");
   property p_stat; !$past(rst) |-> status_byte1_ff[7] == $past(protection_lock_bit_ff) &&
      status_byte1_ff[1] == $past(write_enable_latch_ff) && status_byte1_ff[3:2] ==
      ($past(sector_prot_ff) == 16'hFFFF ? 2'b11 : $past(sector_prot_ff) == 16'h0000 ? 2'b00
      : 2'b01); endproperty
   a_stat: assert property (p_stat) else $error("status view wrong");
   property p_wp; $fell(protection_lock_bit_ff) && !$past(rst) |-> $past(wp_n, 2); endproperty
   a_wp: assert property (p_wp) else $error("lock cleared with pin low");
   property p_lset; $rose(protection_lock_bit_ff)
      |-> $past(write_enable_latch_ff) && !write_enable_latch_ff; endproperty
   a_lset: assert property (p_lset) else $error("lock set without latch");
endmodule
bind flash_sector_protection_ctrl flash_prot_sva flash_prot_sva_i (.clock(clock), .rst(rst),
   .cs_n(cs_n), .wp_n(wp_n), .suspend_any(suspend_any), .sector_prot_ff(sector_prot_ff),
   .write_enable_latch_ff(write_enable_latch_ff),
   .protection_lock_bit_ff(protection_lock_bit_ff), .status_byte1_ff(status_byte1_ff));
`default_nettype wire

/* File: tb/spi_host_model.sv */
// Serial host model that sends command frames in mode 0.
`default_nettype none
module spi_host_model (
   input  wire logic clock,
   output var  logic cs_n,
   output var  logic sck,
   output var  logic mosi
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end
   // Each half of the 320 ns link period is four system clocks; sck rests low between frames.
   task automatic xfer(input logic [39:0] data, input int nbits);
      int i;
      @(posedge clock) cs_n <= 1'b0;
      for (i = 0; i < nbits; i++) begin
         mosi <= data[39-i];
         repeat (4) @(posedge clock);
         sck <= 1'b1;
         repeat (4) @(posedge clock);
         sck <= 1'b0;
      end
      repeat (4) @(posedge clock);
      cs_n <= 1'b1;
      mosi <= ~mosi;
   endtask
endmodule
`default_nettype wire

/* File: tb/flash_sector_protection_ctrl_tb.sv */
// Self-checking bench of the sector protection controller.
`include "flash_prot_regs.vh"
`default_nettype none
module flash_sector_protection_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock;
   logic        rst;
   logic        wp_n;
   logic        suspend_any;
   wire logic   cs_n;
   wire logic   sck;
   wire logic   mosi;
   wire logic [15:0] sector_prot_ff;
   wire logic   write_enable_latch_ff;
   wire logic   protection_lock_bit_ff;
   wire logic [7:0] status_byte1_ff;
   int          err_total = 0;
   int          n_checks = 0;
   flash_sector_protection_ctrl flash_sector_protection_ctrl_i (.clock(clock), .rst(rst),
      .cs_n(cs_n), .sck(sck), .mosi(mosi), .wp_n(wp_n), .suspend_any(suspend_any),
      .sector_prot_ff(sector_prot_ff), .write_enable_latch_ff(write_enable_latch_ff),
      .protection_lock_bit_ff(protection_lock_bit_ff), .status_byte1_ff(status_byte1_ff));
   spi_host_model spi_host_model_i (.clock(clock), .cs_n(cs_n), .sck(sck), .mosi(mosi));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic frame(input logic [39:0] data, input int nbits);
      spi_host_model_i.xfer(data, nbits);
      repeat (8) @(posedge clock);
   endtask
   // Optionally sets the latch, sends one command and checks the stored state.
   task automatic op(input logic [39:0] data, input int nbits, input logic wren,
                     input logic [15:0] exp_sec, input logic exp_lock);
      if (wren) frame({`OPC_WRITE_ENABLE, 32'h0}, 8);
      frame(data, nbits);
      chk("sectors", exp_sec, sector_prot_ff);
      chk("lock", {15'h0, exp_lock}, {15'h0, protection_lock_bit_ff});
      chk("latch", 16'h0000, {15'h0, write_enable_latch_ff});
   endtask
   initial begin
      repeat (30000) @(posedge clock);
      err_total++;
      end_sim;
   end
   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      suspend_any = 1'b0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      chk("reset sectors", 16'hFFFF, sector_prot_ff);
      chk("reset status", 16'h001C, {8'h00, status_byte1_ff});
      frame({`OPC_WRITE_ENABLE, 32'h0}, 8);
      chk("latch set", 16'h0001, {15'h0, write_enable_latch_ff});
      op({8'h39, 24'h03ABCD, 8'hA5}, 40, 1'b0, 16'hFFF7, 1'b0);
      op({8'h39, 24'h050000, 8'h00}, 32, 1'b0, 16'hFFF7, 1'b0);
      op({8'h39, 24'h050000, 8'h00}, 24, 1'b1, 16'hFFF7, 1'b0);
      op({8'h39, 24'h050000, 8'h00}, 33, 1'b1, 16'hFFF7, 1'b0);
      op({8'h36, 24'hF30000, 8'h00}, 32, 1'b1, 16'hFFFF, 1'b0);
      op({8'h01, 8'h00, 24'h0}, 16, 1'b1, 16'h0000, 1'b0);
      op({8'h01, 8'h7F, 24'h0}, 16, 1'b1, 16'hFFFF, 1'b0);
      op({8'h01, 8'h14, 24'h0}, 16, 1'b1, 16'hFFFF, 1'b0);
      op({8'h01, 8'h00, 24'h0}, 16, 1'b1, 16'h0000, 1'b0);
      chk("status none", 16'h0010, {8'h00, status_byte1_ff});
      op({8'h01, 8'hF0, 24'h0}, 16, 1'b1, 16'h0000, 1'b1);
      chk("status lock", 16'h0090, {8'h00, status_byte1_ff});
      op({8'h36, 24'h010000, 8'h00}, 32, 1'b1, 16'h0000, 1'b1);
      wp_n <= 1'b0;
      op({8'h01, 8'h0F, 24'h0}, 16, 1'b1, 16'h0000, 1'b1);
      chk("status pin", 16'h0080, {8'h00, status_byte1_ff});
      wp_n <= 1'b1;
      op({8'h01, 8'h0F, 24'h0}, 16, 1'b1, 16'h0000, 1'b0);
      op({8'h01, 8'hFF, 24'h0}, 16, 1'b1, 16'hFFFF, 1'b1);
      op({8'h39, 24'h020000, 8'h00}, 32, 1'b1, 16'hFFFF, 1'b1);
      op({8'h01, 8'h0F, 24'h0}, 16, 1'b1, 16'hFFFF, 1'b0);
      op({8'h39, 24'h040000, 8'h00}, 32, 1'b1, 16'hFFEF, 1'b0);
      suspend_any <= 1'b1;
      op({8'h01, 8'h7F, 24'h0}, 16, 1'b1, 16'hFFEF, 1'b0);
      op({8'h01, 8'h00, 24'h0}, 16, 1'b1, 16'h0000, 1'b0);
      op({8'h01, 8'h7F, 24'h0}, 16, 1'b1, 16'h0000, 1'b0);
      suspend_any <= 1'b0;
      frame({`OPC_WRITE_ENABLE, 32'h0}, 9);
      chk("latch ragged", 16'h0000, {15'h0, write_enable_latch_ff});
      frame({`OPC_WRITE_ENABLE, 32'h0}, 8);
      frame({`OPC_WRITE_DISABLE, 32'h0}, 8);
      chk("latch off", 16'h0000, {15'h0, write_enable_latch_ff});
      op({8'h36, 24'h070000, 8'h00}, 32, 1'b0, 16'h0000, 1'b0);
      frame({`OPC_WRITE_ENABLE, 32'h0}, 8);
      chk("latch again", 16'h0001, {15'h0, write_enable_latch_ff});
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      chk("rerun sectors", 16'hFFFF, sector_prot_ff);
      chk("rerun latch", 16'h0000, {15'h0, write_enable_latch_ff});
      end_sim;
   end
endmodule
`default_nettype wire
